// ==== pkg/mdr_cfg.svh ====
`ifndef MDR_CFG_SVH
`define MDR_CFG_SVH

// Register map, word addresses on the plain register port
`define MDR_ADDR_W 8
`define MDR_TX_HDP_BASE 8'h00
`define MDR_RX_HDP_BASE 8'h08
`define MDR_TX_CP_BASE 8'h10
`define MDR_RX_CP_BASE 8'h18
`define MDR_STAT_GOOD 8'h20
`define MDR_STAT_BCAST 8'h21
`define MDR_STAT_MCAST 8'h22
`define MDR_STAT_PAUSE 8'h23
`define MDR_MAC_CTRL 8'h28
`define MDR_STATUS 8'h29
`define MDR_MAX_LEN 8'h2A

// Control register field positions
`define MDR_CTRL_WR_DEC_BIT 0
`define MDR_CTRL_FLOW_EN_BIT 1
`define MDR_CTRL_STAT_IE_BIT 2
`define MDR_CTRL_W 3

// Reset values
`define MDR_CTRL_RST 3'h0
`define MDR_MAX_LEN_RST 16'h05EE
`define MDR_STAT_RST 32'h0000_0000

// Frame constants
`define MDR_MIN_LEN 16'h0040
`define MDR_PAUSE_TYPE 16'h8808
`define MDR_PAUSE_OPCODE 16'h0001
`define MDR_HALF_SCALE_BIT 31

// Statistics clear delay after reset release, in clocks
`define MDR_STAT_CLR_CYC 38

`endif

// ==== pkg/mdr_pkg.sv ====
package mdr_pkg;
   // Statistics counter index
   typedef enum logic [1:0] {
      STAT_GOOD,
      STAT_BCAST,
      STAT_MCAST,
      STAT_PAUSE
   } mdr_stat_t;

   // Post-reset clear sequencer
   typedef enum logic [1:0] {
      CLR_WAIT,
      CLR_DONE
   } mdr_clr_state_t;
endpackage

// ==== design/mdr_regs.sv ====
`include "mdr_cfg.svh"

module mdr_regs #(
   parameter int NUM_CH = 8,
   parameter int STAT_CLR_CYC = `MDR_STAT_CLR_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register port
   input wire logic [`MDR_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Receive classifier frame event
   input wire logic rx_frame_done,
   input wire logic rx_addr_match,
   input wire logic rx_promisc,
   input wire logic rx_is_broadcast,
   input wire logic rx_is_multicast,
   input wire logic [15:0] rx_frame_len,
   input wire logic rx_crc_err,
   input wire logic rx_align_err,
   input wire logic rx_code_err,
   input wire logic rx_overrun,
   input wire logic [15:0] rx_type_field,
   input wire logic [15:0] rx_opcode,
   // DMA engine and interrupt combiner
   output logic [NUM_CH-1:0] tx_queue_start,
   output logic [NUM_CH-1:0] rx_queue_enable,
   output logic [NUM_CH-1:0] tx_cp_written,
   output logic [NUM_CH-1:0] rx_cp_written,
   output logic [31:0] cp_value,
   output logic hdp_write_error,
   output logic statistics_pending_interrupt
);

   localparam int CW = $clog2(STAT_CLR_CYC + 1);
   localparam int CHW = $clog2(NUM_CH);

   // Pointer storage
   logic [31:0] tx_queue_head_pointer_ff [NUM_CH];
   logic [31:0] rx_queue_head_pointer_ff [NUM_CH];
   logic [31:0] tx_completion_pointer_ff [NUM_CH];
   logic [31:0] rx_completion_pointer_ff [NUM_CH];
   // Statistics
   logic [31:0] stat_ff [4];
   logic [31:0] nxt_stat [4];
   // Control
   logic [`MDR_CTRL_W-1:0] mac_control_register_ff;
   logic [15:0] rx_max_frame_length_ff;
   logic hdp_err_sticky_ff;
   mdr_pkg::mdr_clr_state_t clr_state_ff;
   logic [CW-1:0] clr_cnt_ff;
   logic clr_now;
   logic [3:0] inc;
   logic [3:0] stat_wr;
   logic len_ok, err_free, good, pause;

   // Decode a register window: base address to channel hit
   function automatic logic in_win(input logic [`MDR_ADDR_W-1:0] a,
                                   input logic [`MDR_ADDR_W-1:0] base);
      in_win = (a >= base) && (a < base + `MDR_ADDR_W'(NUM_CH));
   endfunction

   function automatic logic [CHW-1:0] ch_of(
         input logic [`MDR_ADDR_W-1:0] a,
         input logic [`MDR_ADDR_W-1:0] base);
      logic [`MDR_ADDR_W-1:0] d;
      d = a - base;
      ch_of = d[CHW-1:0];
   endfunction

   // Classification; overrun deliberately not looked at
   assign len_ok = (rx_frame_len >= `MDR_MIN_LEN) &&
                   (rx_frame_len <= rx_max_frame_length_ff);
   assign err_free = !rx_crc_err && !rx_align_err && !rx_code_err;
   assign good = rx_frame_done && (rx_addr_match || rx_promisc) &&
                 len_ok && err_free;
   assign pause = rx_frame_done && len_ok && err_free &&
                  (rx_type_field == `MDR_PAUSE_TYPE) &&
                  (rx_opcode == `MDR_PAUSE_OPCODE) &&
                  mac_control_register_ff[`MDR_CTRL_FLOW_EN_BIT];
   assign inc[mdr_pkg::STAT_GOOD] = good;
   assign inc[mdr_pkg::STAT_BCAST] = good && rx_is_broadcast;
   assign inc[mdr_pkg::STAT_MCAST] = good && rx_is_multicast &&
                                     !rx_is_broadcast;
   assign inc[mdr_pkg::STAT_PAUSE] = pause;

   // Software write hits on statistics
   always_comb begin
      stat_wr = '0;
      if (reg_wr && reg_addr == `MDR_STAT_GOOD) begin
         stat_wr[0] = 1'b1;
      end else if (reg_wr && reg_addr == `MDR_STAT_BCAST) begin
         stat_wr[1] = 1'b1;
      end else if (reg_wr && reg_addr == `MDR_STAT_MCAST) begin
         stat_wr[2] = 1'b1;
      end else if (reg_wr && reg_addr == `MDR_STAT_PAUSE) begin
         stat_wr[3] = 1'b1;
      end
   end

   // Post-reset clear timer: the clear lands on a fixed edge
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clr_state_ff <= mdr_pkg::CLR_WAIT;
         clr_cnt_ff <= '0;
      end else begin
         case (clr_state_ff)
            mdr_pkg::CLR_WAIT: begin
               clr_cnt_ff <= clr_cnt_ff + CW'(1);
               if (clr_now) begin
                  clr_state_ff <= mdr_pkg::CLR_DONE;
               end
            end
            default: clr_state_ff <= mdr_pkg::CLR_DONE;
         endcase
      end
   end
   assign clr_now = (clr_state_ff == mdr_pkg::CLR_WAIT) &&
                    (clr_cnt_ff == CW'(STAT_CLR_CYC - 1));

   // Next counter value: decrement/load first, then the event
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         nxt_stat[i] = stat_ff[i];
         if (stat_wr[i]) begin
            if (mac_control_register_ff[`MDR_CTRL_WR_DEC_BIT]) begin
               // Floor at zero so all ones clears to zero, or to one if an event lands in the same cycle
               if (reg_wdata > stat_ff[i]) begin
                  nxt_stat[i] = '0;
               end else begin
                  nxt_stat[i] = stat_ff[i] - reg_wdata;
               end
            end else begin
               nxt_stat[i] = reg_wdata;
            end
         end
         // Event added on top of the write so a write never loses it
         if (inc[i]) begin
            nxt_stat[i] = nxt_stat[i] + 32'h0000_0001;
         end
         if (clr_now) begin
            nxt_stat[i] = `MDR_STAT_RST;
         end
      end
   end

   // Statistics counters
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) begin
            stat_ff[i] <= `MDR_STAT_RST;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            stat_ff[i] <= nxt_stat[i];
         end
      end
   end

   // Pending follows the next values so it tracks every update
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         statistics_pending_interrupt <= 1'b0;
      end else begin
         statistics_pending_interrupt <=
            mac_control_register_ff[`MDR_CTRL_STAT_IE_BIT] &&
            (nxt_stat[0][`MDR_HALF_SCALE_BIT] ||
             nxt_stat[1][`MDR_HALF_SCALE_BIT] ||
             nxt_stat[2][`MDR_HALF_SCALE_BIT] ||
             nxt_stat[3][`MDR_HALF_SCALE_BIT]);
      end
   end

   // Control and maximum length registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mac_control_register_ff <= `MDR_CTRL_RST;
         rx_max_frame_length_ff <= `MDR_MAX_LEN_RST;
      end else if (reg_wr && reg_addr == `MDR_MAC_CTRL) begin
         mac_control_register_ff <= reg_wdata[`MDR_CTRL_W-1:0];
      end else if (reg_wr && reg_addr == `MDR_MAX_LEN) begin
         rx_max_frame_length_ff <= reg_wdata[15:0];
      end
   end

   // Pointer storage; head contents are undefined until software
   // zeroes them, so they are reset to zero here only for safety
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            tx_queue_head_pointer_ff[i] <= '0;
            rx_queue_head_pointer_ff[i] <= '0;
            tx_completion_pointer_ff[i] <= '0;
            rx_completion_pointer_ff[i] <= '0;
         end
      end else if (reg_wr) begin
         if (in_win(reg_addr, `MDR_TX_HDP_BASE)) begin
            tx_queue_head_pointer_ff[ch_of(reg_addr, `MDR_TX_HDP_BASE)]
               <= reg_wdata;
         end else if (in_win(reg_addr, `MDR_RX_HDP_BASE)) begin
            rx_queue_head_pointer_ff[ch_of(reg_addr, `MDR_RX_HDP_BASE)]
               <= reg_wdata;
         end else if (in_win(reg_addr, `MDR_TX_CP_BASE)) begin
            tx_completion_pointer_ff[ch_of(reg_addr, `MDR_TX_CP_BASE)]
               <= reg_wdata;
         end else if (in_win(reg_addr, `MDR_RX_CP_BASE)) begin
            rx_completion_pointer_ff[ch_of(reg_addr, `MDR_RX_CP_BASE)]
               <= reg_wdata;
         end
      end
   end

   // One-cycle start, enable and completion pulses to the DMA side
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_queue_start <= '0;
         rx_queue_enable <= '0;
         tx_cp_written <= '0;
         rx_cp_written <= '0;
         cp_value <= '0;
      end else begin
         tx_queue_start <= '0;
         rx_queue_enable <= '0;
         tx_cp_written <= '0;
         rx_cp_written <= '0;
         if (reg_wr && in_win(reg_addr, `MDR_TX_HDP_BASE)) begin
            tx_queue_start[ch_of(reg_addr, `MDR_TX_HDP_BASE)] <= 1'b1;
         end
         if (reg_wr && in_win(reg_addr, `MDR_RX_HDP_BASE)) begin
            rx_queue_enable[ch_of(reg_addr, `MDR_RX_HDP_BASE)] <= 1'b1;
         end
         if (reg_wr && in_win(reg_addr, `MDR_TX_CP_BASE)) begin
            tx_cp_written[ch_of(reg_addr, `MDR_TX_CP_BASE)] <= 1'b1;
            cp_value <= reg_wdata;
         end
         if (reg_wr && in_win(reg_addr, `MDR_RX_CP_BASE)) begin
            rx_cp_written[ch_of(reg_addr, `MDR_RX_CP_BASE)] <= 1'b1;
            cp_value <= reg_wdata;
         end
      end
   end

   // Sticky error for a head write over a live pointer; read clears,
   // but a new error in the read cycle wins
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hdp_err_sticky_ff <= 1'b0;
      end else if (reg_wr && ((in_win(reg_addr, `MDR_TX_HDP_BASE) &&
            tx_queue_head_pointer_ff[ch_of(reg_addr, `MDR_TX_HDP_BASE)]
               != '0) ||
            (in_win(reg_addr, `MDR_RX_HDP_BASE) &&
            rx_queue_head_pointer_ff[ch_of(reg_addr, `MDR_RX_HDP_BASE)]
               != '0))) begin
         hdp_err_sticky_ff <= 1'b1;
      end else if (reg_rd && reg_addr == `MDR_STATUS) begin
         hdp_err_sticky_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hdp_write_error <= 1'b0;
      end else begin
         hdp_write_error <= hdp_err_sticky_ff;
      end
   end

   // Read data, valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (!reg_rd) begin
         reg_rdata <= '0;
      end else if (in_win(reg_addr, `MDR_TX_HDP_BASE)) begin
         reg_rdata <=
            tx_queue_head_pointer_ff[ch_of(reg_addr, `MDR_TX_HDP_BASE)];
      end else if (in_win(reg_addr, `MDR_RX_HDP_BASE)) begin
         reg_rdata <=
            rx_queue_head_pointer_ff[ch_of(reg_addr, `MDR_RX_HDP_BASE)];
      end else if (in_win(reg_addr, `MDR_TX_CP_BASE)) begin
         reg_rdata <=
            tx_completion_pointer_ff[ch_of(reg_addr, `MDR_TX_CP_BASE)];
      end else if (in_win(reg_addr, `MDR_RX_CP_BASE)) begin
         reg_rdata <=
            rx_completion_pointer_ff[ch_of(reg_addr, `MDR_RX_CP_BASE)];
      end else if (reg_addr == `MDR_STAT_GOOD) begin
         reg_rdata <= stat_ff[0];
      end else if (reg_addr == `MDR_STAT_BCAST) begin
         reg_rdata <= stat_ff[1];
      end else if (reg_addr == `MDR_STAT_MCAST) begin
         reg_rdata <= stat_ff[2];
      end else if (reg_addr == `MDR_STAT_PAUSE) begin
         reg_rdata <= stat_ff[3];
      end else if (reg_addr == `MDR_MAC_CTRL) begin
         reg_rdata <= {29'h0, mac_control_register_ff};
      end else if (reg_addr == `MDR_STATUS) begin
         reg_rdata <= {30'h0, statistics_pending_interrupt,
                       hdp_err_sticky_ff};
      end else if (reg_addr == `MDR_MAX_LEN) begin
         reg_rdata <= {16'h0, rx_max_frame_length_ff};
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule // mdr_regs

// ==== verif/mdr_regs_props.sv ====
module mdr_regs_props #(
   parameter int NUM_CH = 8
) (
   // Clock and reset
   input logic core_clk,
   input logic rstn,
   // Register port and frame strobe
   input logic [7:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic reg_wr,
   input logic rx_frame_done,
   // Outputs under watch
   input logic [NUM_CH-1:0] tx_queue_start,
   input logic [NUM_CH-1:0] rx_queue_enable,
   input logic [NUM_CH-1:0] tx_cp_written,
   input logic [NUM_CH-1:0] rx_cp_written,
   input logic [31:0] cp_value,
   input logic hdp_write_error,
   input logic statistics_pending_interrupt
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Head writes pulse exactly the addressed channel, one cycle later
   chk_tx_start: assert property (reg_wr && reg_addr < 8'h08 |=>
      tx_queue_start == NUM_CH'(1) << $past(reg_addr[2:0]))
      else $error("tx start pulse mismatch");
   chk_rx_enable: assert property (reg_wr && reg_addr[7:3] == 5'h01 |=>
      rx_queue_enable == NUM_CH'(1) << $past(reg_addr[2:0]))
      else $error("rx enable pulse mismatch");
   chk_no_start: assert property (!reg_wr |=>
      tx_queue_start == '0 && rx_queue_enable == '0)
      else $error("queue pulse without write");
   // Completion value reaches the interrupt combiner with its pulse
   chk_cp_value: assert property (reg_wr && reg_addr[7:4] == 4'h1 |=>
      cp_value == $past(reg_wdata) && (tx_cp_written | rx_cp_written) != '0)
      else $error("completion value mismatch");
   chk_cp_quiet: assert property (!reg_wr |=>
      (tx_cp_written | rx_cp_written) == '0 && $stable(cp_value))
      else $error("completion pulse without write");
   // Error flag lags the offending write by two edges
   chk_hdp_err: assert property ($rose(hdp_write_error) |->
      $past(reg_wr, 2) && $past(reg_addr, 2) < 8'h10)
      else $error("head error without head write");
   chk_pend_rise: assert property ($rose(statistics_pending_interrupt) |->
      $past(rx_frame_done || reg_wr))
      else $error("pending rose without cause");
   chk_pend_fall: assert property ($fell(statistics_pending_interrupt) |->
      $past(reg_wr))
      else $error("pending fell without write");
   chk_pend_steady: assert property (!rx_frame_done && !reg_wr |=>
      $stable(statistics_pending_interrupt))
      else $error("pending moved while idle");
endmodule // mdr_regs_props

bind mdr_regs mdr_regs_props #(.NUM_CH(NUM_CH)) props_u (.core_clk, .rstn,
   .reg_addr, .reg_wdata, .reg_wr, .rx_frame_done, .tx_queue_start,
   .rx_queue_enable, .tx_cp_written, .rx_cp_written, .cp_value,
   .hdp_write_error, .statistics_pending_interrupt);

// ==== verif/mdr_rx_model.sv ====
module mdr_rx_model (
   // Clock
   input logic core_clk,
   // Frame event
   output logic rx_frame_done,
   output logic rx_addr_match,
   output logic rx_promisc,
   output logic rx_is_broadcast,
   output logic rx_is_multicast,
   output logic rx_crc_err,
   output logic rx_align_err,
   output logic rx_code_err,
   output logic rx_overrun,
   output logic [15:0] rx_frame_len,
   output logic [15:0] rx_type_field,
   output logic [15:0] rx_opcode
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] fl;
   // Qualifier flags travel packed inside the model
   assign {rx_addr_match, rx_promisc, rx_is_broadcast, rx_is_multicast,
      rx_crc_err, rx_align_err, rx_code_err, rx_overrun} = fl;
   initial begin
      rx_frame_done = 1'b0;
      fl = 8'h00;
      rx_frame_len = 16'h0000;
      rx_type_field = 16'h0000;
      rx_opcode = 16'h0000;
   end
   // One frame per cycle; strobe stays up so frames may run back to back
   task send(input logic [15:0] len, input logic [7:0] f,
      input logic [15:0] ty, input logic [15:0] op);
      rx_frame_done <= 1'b1;
      fl <= f;
      rx_frame_len <= len;
      rx_type_field <= ty;
      rx_opcode <= op;
      @(posedge core_clk);
   endtask
   // Between frames the qualifiers are garbage, never the last frame
   task idle;
      rx_frame_done <= 1'b0;
      fl <= ~fl;
      rx_frame_len <= ~rx_frame_len;
      rx_type_field <= ~rx_type_field;
      rx_opcode <= ~rx_opcode;
   endtask
endmodule // mdr_rx_model

// ==== verif/mdr_regs_tb.sv ====
module mdr_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rstn, reg_wr, reg_rd, flow;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, cp_value;
   logic rx_frame_done, rx_addr_match, rx_promisc, rx_is_broadcast;
   logic rx_is_multicast, rx_crc_err, rx_align_err, rx_code_err, rx_overrun;
   logic [15:0] rx_frame_len, rx_type_field, rx_opcode;
   logic [7:0] tx_queue_start, rx_queue_enable, tx_cp_written, rx_cp_written;
   logic hdp_write_error, statistics_pending_interrupt;
   logic [31:0] exp [4];
   int error_cnt = 0;
   int compares = 0;

   // Short clear delay keeps the reset scenario brief
   mdr_regs #(.STAT_CLR_CYC(4)) dut_u (.core_clk, .rstn, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_frame_done,
      .rx_addr_match, .rx_promisc, .rx_is_broadcast, .rx_is_multicast,
      .rx_frame_len, .rx_crc_err, .rx_align_err, .rx_code_err, .rx_overrun,
      .rx_type_field, .rx_opcode, .tx_queue_start, .rx_queue_enable,
      .tx_cp_written, .rx_cp_written, .cp_value, .hdp_write_error,
      .statistics_pending_interrupt);
   mdr_rx_model rx_u (.core_clk, .rx_frame_done, .rx_addr_match,
      .rx_promisc, .rx_is_broadcast, .rx_is_multicast, .rx_crc_err,
      .rx_align_err, .rx_code_err, .rx_overrun, .rx_frame_len,
      .rx_type_field, .rx_opcode);

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Full-word write, then a read with data in the following cycle
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // Expected counts follow the frame classes, then the frame goes out
   task frm(input logic [15:0] len, input logic [7:0] f,
      input logic [15:0] ty, input logic [15:0] op);
      logic ok;
      logic g;
      ok = len >= 16'h0040 && len <= 16'h05EE && f[3:1] == 3'h0;
      g = ok && (f[7] || f[6]);
      exp[0] += 32'(g);
      exp[1] += 32'(g && f[5]);
      exp[2] += 32'(g && f[4] && !f[5]);
      exp[3] += 32'(ok && flow && ty == 16'h8808 && op == 16'h0001);
      rx_u.send(len, f, ty, op);
   endtask
   task stop_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #20000;
      error_cnt++;
      stop_test;
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      flow = 1'b0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      wr(8'h20, 32'h5);
      repeat (4) @(posedge core_clk);
      rd(8'h20, 32'h0);
      for (int i = 0; i < 16; i++) wr(8'(i), 32'h0);
      wr(8'h03, 32'h1000);
      chk(32'(tx_queue_start), 32'h8);
      wr(8'h0D, 32'h2000);
      chk(32'(rx_queue_enable), 32'h20);
      rd(8'h2A, 32'h05EE);
      rd(8'h03, 32'h1000);
      chk(32'(hdp_write_error), 32'h0);
      wr(8'h03, 32'h3000);
      @(posedge core_clk);
      #1;
      chk(32'(hdp_write_error), 32'h1);
      rd(8'h29, 32'h1);
      wr(8'h12, 32'hABCD_0010);
      chk(cp_value, 32'hABCD_0010);
      chk(32'(tx_cp_written), 32'h4);
      wr(8'h1F, 32'h1234_0020);
      chk(cp_value, 32'h1234_0020);
      chk(32'(rx_cp_written), 32'h80);
      rd(8'h1F, 32'h1234_0020);
      wr(8'h28, 32'h2);
      flow = 1'b1;
      exp = '{32'h7, 32'hFFFF_FFFF, 32'h0, 32'h0};
      for (int i = 0; i < 4; i++) wr(8'h20 + 8'(i), exp[i]);
      rd(8'h20, 32'h7);
      frm(16'h0040, 8'hA0, 16'h0, 16'h0);
      frm(16'h05EE, 8'h51, 16'h0, 16'h0);
      frm(16'h003F, 8'h80, 16'h0, 16'h0);
      frm(16'h05EF, 8'h80, 16'h0, 16'h0);
      frm(16'h0064, 8'h88, 16'h0, 16'h0);
      frm(16'h0064, 8'h84, 16'h0, 16'h0);
      frm(16'h0064, 8'h82, 16'h0, 16'h0);
      frm(16'h0064, 8'h10, 16'h0, 16'h0);
      frm(16'h0040, 8'h10, 16'h8808, 16'h0001);
      frm(16'h0040, 8'hB0, 16'h8808, 16'h0001);
      frm(16'h0040, 8'h80, 16'h8808, 16'h0002);
      rx_u.idle;
      wr(8'h28, 32'h4);
      flow = 1'b0;
      frm(16'h0040, 8'h10, 16'h8808, 16'h0001);
      rx_u.idle;
      for (int i = 0; i < 4; i++) rd(8'h20 + 8'(i), exp[i]);
      wr(8'h22, 32'h8000_0000);
      chk(32'(statistics_pending_interrupt), 32'h1);
      wr(8'h28, 32'h5);
      wr(8'h22, 32'h1);
      chk(32'(statistics_pending_interrupt), 32'h0);
      wr(8'h20, 32'h3);
      rd(8'h20, exp[0] - 32'h3);
      fork
         wr(8'h20, 32'h2);
         frm(16'h0040, 8'h80, 16'h0, 16'h0);
      join
      rx_u.idle;
      rd(8'h20, exp[0] - 32'h5);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0);
      rd(8'h40, 32'h0);
      stop_test;
   end
endmodule // mdr_regs_tb
